// ==== design/ucp_params.svh ====
// constants for the ulpi transceiver link-side block
`ifndef UCP_PARAMS_SVH
`define UCP_PARAMS_SVH
// ahb register byte offsets and control reset value
`define UCP_A_CTRL      8'h00
`define UCP_A_STAT      8'h04
`define UCP_CTRL_RST    1'b1
// ulpi register addresses, reset value and SOF pid
`define UCP_FUNC_ADDR   8'h04
`define UCP_FUNC_SET    8'h05
`define UCP_FUNC_CLR    8'h06
`define UCP_SCR_ADDR    8'h16
`define UCP_EXT_ADDR    6'h2F
`define UCP_FUNC_RST    8'h41
`define UCP_SOF_PID     4'h5
// line-state report delays in clocks
`define UCP_JK_DLY      5'd4
`define UCP_SE0_HS      5'd4
`define UCP_SE0_FS      5'd5
`define UCP_SE0_LS      5'd17
// transmit start and end delays in clocks
`define UCP_TXS_HS      8'd1
`define UCP_TXS_FS      8'd6
`define UCP_TXS_LS      8'd74
`define UCP_TXE_PKT     8'd3
`define UCP_TXE_SOF     8'd6
`define UCP_TXE_FSLS    8'd1
// receive start and end delays in clocks
`define UCP_RXS         8'd5
`define UCP_RXE_HS      8'd5
`define UCP_RXE_FS      8'd17
`define UCP_RXE_LS      8'd122
`endif

// ==== design/ucp_pkg.sv ====
// types for the ulpi transceiver link-side block
package ucp_pkg;
    typedef enum logic [3:0] {
        UCP_IDLE, UCP_REG_CMD, UCP_REG_EXT, UCP_REG_WDATA, UCP_REG_WSTOP,
        UCP_RD_TURN, UCP_CMD_TURN, UCP_CMD_BYTE, UCP_TURN_BACK,
        UCP_TX_WAIT, UCP_TX_DATA, UCP_TX_END, UCP_RX_WAIT, UCP_RX_RUN, UCP_RX_TAIL
    } ucp_state_e;

    typedef struct packed {
        ucp_state_e  state;
        logic [7:0]  cnt;
        logic [4:0]  lsCnt;
        logic [1:0]  lsSync1;
        logic [1:0]  lsSync2;
        logic [1:0]  lsTrack;
        logic        pending;
        logic [7:0]  addr;
        logic        isRead;
        logic        isSof;
        logic [7:0]  wdata;
        logic [7:0]  funcCtrl;
        logic [7:0]  scratch;
        logic [7:0]  abortCnt;
        logic        ctrlEn;
        logic [7:0]  dataOut;
        logic        dataOe;
        logic        dir;
        logic        nxt;
        logic        hWr;
        logic [7:0]  hAddr;
        logic [31:0] hrdata;
        logic        hready;
        logic        hresp;
    } ucp_regs_s;
endpackage : ucp_pkg

// ==== design/ucp_ulpi_phy_link.sv ====
// ulpi transceiver link side: register access, line-state reports, packet timing
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ucp_params.svh"
module ucp_ulpi_phy_link (
    input  wire logic        clk,          // 50 MHz system clock
    input  wire logic        rst_b,        // synchronous reset, active low
    input  wire logic        hsel,         // ahb slave select
    input  wire logic [31:0] haddr,        // ahb address
    input  wire logic [1:0]  htrans,       // ahb transfer type
    input  wire logic        hwrite,       // ahb write
    input  wire logic [2:0]  hsize,        // ahb size, word only
    input  wire logic [31:0] hwdata,       // ahb write data
    input  wire logic        hready,       // ahb bus ready
    output logic             hreadyout,    // ahb slave ready
    output logic             hresp,        // ahb response, always okay
    output logic [31:0]      hrdata,       // ahb read data
    input  wire logic [7:0]  ulpiDataIn,   // ulpi data from link
    output logic [7:0]       ulpiDataOut,  // ulpi data to link
    output logic             ulpiDataOe,   // high while we drive data
    output logic             ulpiDir,      // bus owned by transceiver
    output logic             ulpiNxt,      // throttle / rx active
    input  wire logic        ulpiStp,      // link stop
    input  wire logic        lineDp,       // dp receiver pin
    input  wire logic        lineDm,       // dm receiver pin
    input  wire logic        rxActive,     // receiver framing, same clock
    input  wire logic        rxValid,      // received byte strobe
    input  wire logic [7:0]  rxData,       // received byte
    output logic [1:0]       speedSel,     // transceiver_speed_select
    output logic             termSel,      // termination_select
    output logic [1:0]       operating_mode        // operating_mode
);
    import ucp_pkg::*;

    ucp_regs_s  s_q;
    ucp_regs_s  s_d;
    logic [4:0] lsDly;
    logic [7:0] txsDly;
    logic [7:0] txeDly;
    logic [7:0] rxeDly;
    logic [7:0] regRd;
    logic [7:0] rxCmdOn;
    logic [7:0] rxCmdOff;
    logic       regBusy;
    logic       abortNow;
    logic       txGo;

    // delays picked by the current bus speed; 11b behaves as full speed
    always_comb begin
        case (s_q.funcCtrl[1:0])
            2'b00: begin
                lsDly  = (s_q.lsSync2 == 2'b00) ? `UCP_SE0_HS : `UCP_JK_DLY;
                txsDly = `UCP_TXS_HS;
                txeDly = s_q.isSof ? `UCP_TXE_SOF : `UCP_TXE_PKT;
                rxeDly = `UCP_RXE_HS;
            end
            2'b10: begin
                lsDly  = (s_q.lsSync2 == 2'b00) ? `UCP_SE0_LS : `UCP_JK_DLY;
                txsDly = `UCP_TXS_LS;
                txeDly = `UCP_TXE_FSLS;
                rxeDly = `UCP_RXE_LS;
            end
            default: begin
                lsDly  = (s_q.lsSync2 == 2'b00) ? `UCP_SE0_FS : `UCP_JK_DLY;
                txsDly = `UCP_TXS_FS;
                txeDly = `UCP_TXE_FSLS;
                rxeDly = `UCP_RXE_FS;
            end
        endcase
    end

    // register read mux, rxcmd bytes and abort condition
    assign regRd = (s_q.addr == `UCP_FUNC_ADDR || s_q.addr == `UCP_FUNC_SET ||
                    s_q.addr == `UCP_FUNC_CLR) ? s_q.funcCtrl :
                   (s_q.addr == `UCP_SCR_ADDR) ? s_q.scratch : 8'h00;
    assign rxCmdOn  = {4'h1, 2'b00, s_q.lsTrack};
    assign rxCmdOff = {4'h0, 2'b00, s_q.lsTrack};
    assign regBusy  = (s_q.state == UCP_REG_CMD) || (s_q.state == UCP_REG_EXT) ||
                      (s_q.state == UCP_REG_WDATA) || (s_q.state == UCP_REG_WSTOP && !ulpiStp);
    // any reason to take the bus while the link holds it ends the access
    assign abortNow = s_q.pending || rxActive;
    assign txGo     = (s_q.state == UCP_IDLE) && !abortNow && ulpiDataIn[7:6] == 2'b01;

    // all next-state logic
    always_comb begin
        s_d = s_q;
        case (s_q.state)
            UCP_IDLE: begin
                s_d.dataOe = 1'b0;
                if (rxActive) begin
                    s_d.cnt   = `UCP_RXS;
                    s_d.state = UCP_RX_WAIT;
                end else if (s_q.pending) begin
                    s_d.dir   = 1'b1;
                    s_d.state = UCP_CMD_TURN;
                end else if (txGo) begin
                    s_d.isSof = (ulpiDataIn[3:0] == `UCP_SOF_PID);
                    s_d.cnt   = txsDly;
                    s_d.nxt   = (txsDly == 8'd1);
                    s_d.state = (txsDly == 8'd1) ? UCP_TX_DATA : UCP_TX_WAIT;
                end else if (ulpiDataIn[7]) begin
                    s_d.nxt   = 1'b1;
                    s_d.state = UCP_REG_CMD;
                end
            end
            UCP_REG_CMD, UCP_REG_EXT: begin
                if (abortNow) begin
                    s_d.nxt      = 1'b0;
                    s_d.dir      = 1'b1;
                    s_d.abortCnt = s_q.abortCnt + 8'd1;
                    s_d.state    = UCP_CMD_TURN;
                end else begin
                    if (s_q.state == UCP_REG_CMD) begin
                        s_d.isRead = ulpiDataIn[6];
                        s_d.addr   = {2'b00, ulpiDataIn[5:0]};
                    end else begin
                        s_d.addr = ulpiDataIn;
                    end
                    if (s_q.state == UCP_REG_CMD && ulpiDataIn[5:0] == `UCP_EXT_ADDR) begin
                        s_d.state = UCP_REG_EXT;
                    end else if (s_d.isRead) begin
                        s_d.nxt   = 1'b0;
                        s_d.dir   = 1'b1;
                        s_d.state = UCP_RD_TURN;
                    end else begin
                        s_d.state = UCP_REG_WDATA;
                    end
                end
            end
            UCP_REG_WDATA: begin
                s_d.nxt = 1'b0;
                if (abortNow) begin
                    s_d.dir      = 1'b1;
                    s_d.abortCnt = s_q.abortCnt + 8'd1;
                    s_d.state    = UCP_CMD_TURN;
                end else begin
                    s_d.wdata = ulpiDataIn;
                    s_d.state = UCP_REG_WSTOP;
                end
            end
            UCP_REG_WSTOP: begin
                // a stop completes the write even if a report is waiting
                if (ulpiStp) begin
                    if (s_q.addr == `UCP_FUNC_ADDR) s_d.funcCtrl = s_q.wdata;
                    if (s_q.addr == `UCP_FUNC_SET) s_d.funcCtrl = s_q.funcCtrl | s_q.wdata;
                    if (s_q.addr == `UCP_FUNC_CLR) s_d.funcCtrl = s_q.funcCtrl & ~s_q.wdata;
                    if (s_q.addr == `UCP_SCR_ADDR) s_d.scratch = s_q.wdata;
                    s_d.state = UCP_IDLE;
                end else if (abortNow) begin
                    s_d.dir      = 1'b1;
                    s_d.abortCnt = s_q.abortCnt + 8'd1;
                    s_d.state    = UCP_CMD_TURN;
                end
            end
            UCP_RD_TURN: begin
                s_d.dataOe  = 1'b1;
                s_d.dataOut = regRd;
                s_d.state   = UCP_CMD_BYTE;
            end
            UCP_CMD_TURN: begin
                s_d.dataOe  = 1'b1;
                s_d.dataOut = rxCmdOff;
                s_d.pending = 1'b0;
                s_d.state   = UCP_CMD_BYTE;
            end
            UCP_CMD_BYTE: begin
                s_d.dir    = 1'b0;
                s_d.dataOe = 1'b0;
                s_d.state  = UCP_TURN_BACK;
            end
            UCP_TURN_BACK: s_d.state = UCP_IDLE;
            UCP_TX_WAIT: begin
                s_d.cnt = s_q.cnt - 8'd1;
                if (s_q.cnt == 8'd1) begin
                    s_d.nxt   = 1'b1;
                    s_d.state = UCP_TX_DATA;
                end
            end
            UCP_TX_DATA: begin
                if (ulpiStp) begin
                    s_d.nxt   = 1'b0;
                    s_d.cnt   = txeDly;
                    s_d.state = UCP_TX_END;
                end
            end
            UCP_TX_END: begin
                s_d.cnt = s_q.cnt - 8'd1;
                if (s_q.cnt <= 8'd1) s_d.state = UCP_IDLE;
            end
            UCP_RX_WAIT: begin
                s_d.cnt = s_q.cnt - 8'd1;
                if (s_q.cnt <= 8'd1) begin
                    s_d.dir   = 1'b1;
                    s_d.nxt   = 1'b1;
                    s_d.state = UCP_RX_RUN;
                end
            end
            UCP_RX_RUN: begin
                s_d.dataOe  = 1'b1;
                s_d.nxt     = rxActive && rxValid;
                s_d.dataOut = (rxActive && rxValid) ? rxData : rxCmdOn;
                if (!rxActive) begin
                    s_d.cnt   = rxeDly;
                    s_d.state = UCP_RX_TAIL;
                end
            end
            UCP_RX_TAIL: begin
                s_d.cnt = s_q.cnt - 8'd1;
                if (s_q.cnt <= 8'd1) begin
                    s_d.dataOut = rxCmdOff;
                    s_d.pending = 1'b0;
                    s_d.state   = UCP_CMD_BYTE;
                end
            end
            default: s_d.state = UCP_IDLE;
        endcase

        // line-state sync and report scheduling; placed after the fsm so a set wins over a clear
        s_d.lsSync1 = {lineDm, lineDp};
        s_d.lsSync2 = s_q.lsSync1;
        if (s_q.lsSync2 != s_q.lsTrack) begin
            s_d.lsTrack = s_q.lsSync2;
            s_d.lsCnt   = lsDly - 5'd3;
            s_d.pending = 1'b0;
        end else if (s_q.lsCnt != 5'd0) begin
            s_d.lsCnt = s_q.lsCnt - 5'd1;
            if (s_q.lsCnt == 5'd1) s_d.pending = s_q.ctrlEn;
        end

        // ahb slave: zero wait states, read data prepared in the address phase
        s_d.hWr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_d.hWr    = hwrite && hsize == 3'b010;
            s_d.hAddr  = haddr[7:0];
            s_d.hrdata = 32'h00000000;
            if (!hwrite && haddr[7:0] == `UCP_A_CTRL) s_d.hrdata = {31'h00000000, s_q.ctrlEn};
            if (!hwrite && haddr[7:0] == `UCP_A_STAT) begin
                s_d.hrdata = {8'h00, s_q.abortCnt, s_q.funcCtrl, 6'h00, s_q.lsTrack};
            end
        end
        if (s_q.hWr && s_q.hAddr == `UCP_A_CTRL) s_d.ctrlEn = hwdata[0];
        s_d.hready = 1'b1;
        s_d.hresp  = 1'b0;
    end

    // one register stage holds all state
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_q          <= '0;
            s_q.state    <= UCP_IDLE;
            s_q.funcCtrl <= `UCP_FUNC_RST;
            s_q.ctrlEn   <= `UCP_CTRL_RST;
            s_q.hready   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign hreadyout   = s_q.hready;
    assign hresp       = s_q.hresp;
    assign hrdata      = s_q.hrdata;
    assign ulpiDataOut = s_q.dataOut;
    assign ulpiDataOe  = s_q.dataOe;
    assign ulpiDir     = s_q.dir;
    assign ulpiNxt     = s_q.nxt;
    assign speedSel    = s_q.funcCtrl[1:0];
    assign termSel     = s_q.funcCtrl[2];
    assign operating_mode      = s_q.funcCtrl[4:3];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_abort_takes_bus: assert property (regBusy && abortNow |=> ulpiDir && !ulpiNxt &&
        s_q.abortCnt == $past(s_q.abortCnt) + 8'd1 ##1 ulpiDataOe) else $error("abort missed");
    a_ext_addr_step: assert property (s_q.state == UCP_REG_CMD && !abortNow &&
        ulpiDataIn[5:0] == `UCP_EXT_ADDR |=> s_q.state == UCP_REG_EXT && ulpiNxt) else $error("ext addr");
    a_func_write: assert property (s_q.state == UCP_REG_WSTOP && ulpiStp &&
        s_q.addr == `UCP_FUNC_ADDR |=> operating_mode == $past(s_q.wdata[4:3])) else $error("func write");
    a_jk_report: assert property ((s_q.lsSync2 != s_q.lsTrack && s_q.lsSync2 != 2'b00 &&
        s_q.ctrlEn) ##1 (s_q.lsSync2 == s_q.lsTrack)[*2] |-> s_q.pending) else $error("jk report");
    a_tx_start_hs: assert property (txGo && speedSel == 2'b00 |=> ulpiNxt) else $error("hs tx start");
    a_tx_start_fs: assert property (txGo && speedSel == 2'b01 |=> !ulpiNxt[*6] ##1 ulpiNxt)
        else $error("fs tx start");
    a_rx_start: assert property (s_q.state == UCP_IDLE && rxActive |=> !ulpiDir[*5] ##1
        (ulpiDir && ulpiNxt)) else $error("rx start");
    a_rx_end_hs: assert property (s_q.state == UCP_RX_RUN && !rxActive && speedSel == 2'b00 |=>
        (s_q.state == UCP_RX_TAIL)[*5] ##1 (ulpiDataOe && !ulpiDataOut[4])) else $error("rx end");
    c_abort: cover property (regBusy && abortNow);
    c_ext_write: cover property (s_q.state == UCP_REG_EXT ##1 s_q.state == UCP_REG_WDATA);
    c_rx_packet: cover property (s_q.state == UCP_RX_TAIL ##1 s_q.state == UCP_CMD_BYTE);
    c_sof_end: cover property (s_q.state == UCP_TX_END && s_q.isSof);
endmodule : ucp_ulpi_phy_link

// ==== sim/ucp_link_model.sv ====
// behavioural ulpi link controller facing the transceiver block
`timescale 1ns/1ps
module ucp_link_model (
    clk,          // interface clock
    ulpiDataOut,  // byte from the transceiver
    ulpiDir,      // transceiver owns the bus
    ulpiNxt,      // byte accepted or rx byte valid
    ulpiDataIn,   // byte to the transceiver, 00 when idle
    ulpiStp,      // one-cycle stop pulse
    tries         // attempts taken by the last register access
);
    input  wire logic       clk;
    input  wire logic [7:0] ulpiDataOut;
    input  wire logic       ulpiDir;
    input  wire logic       ulpiNxt;
    output logic      [7:0] ulpiDataIn;
    output logic            ulpiStp;
    output int              tries;

    initial begin
        ulpiDataIn = 8'h00;
        ulpiStp    = 1'b0;
        tries      = 0;
    end

    // bus is ours again only after dir falls and one turnaround cycle passes
    task automatic idleWait();
        int n;
        for (n = 0; n < 400 && ulpiDir; n++)
            @(posedge clk);
        @(posedge clk);
    endtask : idleWait

    // hold a byte until nxt is sampled; dir taking the bus ends the attempt
    task automatic put(input logic [7:0] b, output bit ok);
        int n;
        ulpiDataIn <= b;
        ok = 1'b0;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (ulpiDir) begin
                ulpiDataIn <= 8'h00;
                break;
            end
            ok = ulpiNxt;
            if (ok)
                break;
        end
    endtask : put

    // register read or write, retried until it completes, at most eight times
    task automatic regAcc(input bit rd, input bit ext, input logic [7:0] a,
                          input logic [7:0] wd, output logic [7:0] rdv);
        bit ok;
        rdv = 8'h00;
        for (tries = 1; tries <= 8; tries++) begin
            idleWait();
            put({1'b1, rd, ext ? 6'h2F : a[5:0]}, ok);
            if (ok && ext)
                put(a, ok);
            if (ok && !rd)
                put(wd, ok);
            if (ok) begin
                ulpiDataIn <= 8'h00;
                ulpiStp    <= !rd;
                @(posedge clk);
                ulpiStp    <= 1'b0;
                // one more edge: read data stands now, and a write has landed before the caller looks
                @(posedge clk);
                if (rd)
                    rdv = ulpiDataOut;
                break;
            end
        end
    endtask : regAcc

    // one-byte packet; lat counts edges from the command until nxt is seen
    task automatic tx(input logic [7:0] cmd, output int lat);
        ulpiDataIn <= cmd;
        for (lat = 1; lat < 300; lat++) begin
            @(posedge clk);
            if (ulpiNxt)
                break;
        end
        ulpiDataIn <= 8'hC3;
        @(posedge clk);
        ulpiDataIn <= 8'h00;
        ulpiStp    <= 1'b1;
        @(posedge clk);
        ulpiStp    <= 1'b0;
    endtask : tx
endmodule : ucp_link_model

// ==== sim/ulpi_reset_chirp_packet_timing_test.sv ====
// self-checking bench: ahb and ulpi register access, receive, transmit and line reports
`timescale 1ns/1ps
`include "ucp_params.svh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module ulpi_reset_chirp_packet_timing_test;
    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, ulpiDataOe, ulpiDir, ulpiNxt, ulpiStp;
    logic        lineDp, lineDm, rxActive, rxValid, termSel, seen;
    logic [1:0]  htrans, speedSel, operating_mode;
    logic [2:0]  hsize;
    logic [7:0]  ulpiDataIn, ulpiDataOut, rxData, b;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          failCount, nChecks, tries, k1, k2, k3, kJ, kS, kH, i;

    ucp_ulpi_phy_link dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ulpiDataIn(ulpiDataIn), .ulpiDataOut(ulpiDataOut),
        .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiStp(ulpiStp),
        .lineDp(lineDp), .lineDm(lineDm), .rxActive(rxActive), .rxValid(rxValid), .rxData(rxData),
        .speedSel(speedSel), .termSel(termSel), .operating_mode(operating_mode));
    ucp_link_model linkU (.clk(clk), .ulpiDataOut(ulpiDataOut), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt),
        .ulpiDataIn(ulpiDataIn), .ulpiStp(ulpiStp), .tries(tries));

    // 50 MHz clock
    always #10 clk = ~clk;

    task automatic closeOut();
        if (failCount == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : closeOut

    function automatic logic sig(input int w);
        return w == 0 ? ulpiNxt : (w == 1 ? ulpiDataOe : hreadyout);
    endfunction : sig

    // bounded wait for nxt, data-enable or hreadyout; k counts the edges
    task automatic waitHi(input int w, output int k);
        for (k = 1; k <= 400; k++) begin
            @(posedge clk);
            if (sig(w) === 1'b1)
                break;
        end
        if (k > 400) begin
            failCount++;
            closeOut();
        end
    endtask : waitHi

    // single word transfer: address phase, then data phase, read data at its end
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        int k;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        waitHi(2, k);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        waitHi(2, k);
        r = hrdata;
        `CHK(hresp, 1'b0)
    endtask : ahb

    function automatic logic inr(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : inr

    // wait for one line-state report, then for the bus to settle
    task automatic lineRep(input logic dm, input logic dp, output int k);
        lineDm <= dm;
        lineDp <= dp;
        waitHi(1, k);
        `CHK(ulpiDataOut[1:0], {dm, dp})
        repeat (4) @(posedge clk);
    endtask : lineRep

    initial begin
        {clk, rst_b, hsel, hwrite, lineDp, lineDm, rxActive, rxValid} = 8'h00;
        {htrans, hsize, haddr, hwdata, rxData} = {2'b00, 3'b010, 32'h0, 32'h0, 8'h00};
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        // reset values, address alias, unmapped and read-only places
        ahb(1'b0, `UCP_A_CTRL, 32'h0, rd);
        `CHK(rd, 32'h00000001)
        ahb(1'b1, `UCP_A_STAT, 32'hFFFFFFFF, rd);
        ahb(1'b0, 32'h00000104, 32'h0, rd);
        `CHK(rd, {16'h0000, `UCP_FUNC_RST, 8'h00})
        ahb(1'b0, 32'h00000008, 32'h0, rd);
        `CHK(rd, 32'h00000000)
        // immediate write, set and clear forms of the function register
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h40, b);
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_SET, 8'h14, b);
        `CHK({operating_mode, termSel, speedSel}, 5'b10100)
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_CLR, 8'h14, b);
        ahb(1'b0, `UCP_A_STAT, 32'h0, rd);
        `CHK(rd[15:8], 8'h40)
        // extended write, then both read forms
        linkU.regAcc(1'b0, 1'b1, `UCP_SCR_ADDR, 8'hA5, b);
        linkU.regAcc(1'b1, 1'b0, `UCP_SCR_ADDR, 8'h00, b);
        `CHK(b, 8'hA5)
        linkU.regAcc(1'b1, 1'b1, `UCP_SCR_ADDR, 8'h00, b);
        `CHK(b, 8'hA5)
        // receiver starting in mid-access aborts it; the link must try again
        fork
            linkU.regAcc(1'b0, 1'b1, `UCP_SCR_ADDR, 8'h3C, b);
            begin
                // receiver starts once the command byte is taken, inside the access
                waitHi(0, k2);
                rxActive <= 1'b1;
                repeat (3) @(posedge clk);
                rxActive <= 1'b0;
            end
        join
        `CHK(tries, 2)
        linkU.regAcc(1'b1, 1'b0, `UCP_SCR_ADDR, 8'h00, b);
        `CHK(b, 8'h3C)
        ahb(1'b0, `UCP_A_STAT, 32'h0, rd);
        `CHK(rd[23:16], 8'h01)
        // receive start delay and one received byte
        rxActive <= 1'b1;
        waitHi(0, k1);
        `CHK(inr(k1 - 1, 5, 6), 1'b1)
        rxValid  <= 1'b1;
        rxData   <= 8'h5A;
        @(posedge clk);
        rxValid  <= 1'b0;
        waitHi(0, k1);
        `CHK(ulpiDataOut, 8'h5A)
        rxActive <= 1'b0;
        linkU.idleWait();
        // transmit start at high, full and low speed, and end delay after a packet and after SOF
        linkU.tx(8'h41, k1);
        linkU.tx(8'h45, k2);
        linkU.tx(8'h41, k3);
        `CHK(inr(k1 - 1, 1, 2), 1'b1)
        `CHK(inr(k2 - k1, 3, 4), 1'b1)
        `CHK(inr(k3 - k1, 6, 9), 1'b1)
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h41, b);
        linkU.tx(8'h41, k1);
        `CHK(inr(k1 - 1, 6, 10), 1'b1)
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h42, b);
        linkU.tx(8'h41, k1);
        `CHK(inr(k1 - 1, 74, 75), 1'b1)
        // line reports at low speed, then at high speed
        lineRep(1'b0, 1'b1, kJ);
        ahb(1'b0, `UCP_A_STAT, 32'h0, rd);
        `CHK(rd[1:0], 2'b01)
        lineRep(1'b0, 1'b0, kS);
        `CHK(inr(kS - kJ, 12, 14), 1'b1)
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h40, b);
        lineRep(1'b1, 1'b0, kH);
        `CHK(kH, kJ)
        lineRep(1'b0, 1'b0, kS);
        `CHK(kS, kH)
        // reset into chirp mode, a nopid chirp command, then back to normal high-speed mode
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h50, b);
        `CHK({operating_mode, termSel, speedSel}, 5'b10000)
        linkU.tx(8'h40, k1);
        `CHK(inr(k1 - 1, 1, 2), 1'b1)
        linkU.regAcc(1'b0, 1'b0, `UCP_FUNC_ADDR, 8'h40, b);
        `CHK({operating_mode, termSel}, 3'b000)
        // reports switched off: a line change must not take the bus
        ahb(1'b1, `UCP_A_CTRL, 32'h0, rd);
        lineDp <= 1'b1;
        seen = 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            seen = seen | ulpiDir;
        end
        `CHK(seen, 1'b0)
        closeOut();
    end
endmodule : ulpi_reset_chirp_packet_timing_test
